/* File: hw/emb_pkg.sv */
package emb_pkg;

    // Pin widths of the expansion port.
    localparam int ADDR_WIDTH = 18;
    localparam int DATA_WIDTH = 24;
    localparam int ATTR_WIDTH = 4;

    // Position of the attribute priority disable bit in the mode word.
    localparam int MODE_WIDTH = 24;
    localparam int ATTR_PRIORITY_DISABLE_BIT = 14;

    // Reset values of the registered pins.
    localparam logic [17:0] ADDR_RESET = 18'h00000;
    localparam logic [23:0] DATA_RESET = 24'h000000;
    localparam logic [3:0] ATTR_RESET = 4'h0;

    // Ownership and power state of the port.
    typedef enum logic [2:0] {
        EMB_RESET = 3'b001,
        EMB_OWNER = 3'b010,
        EMB_IDLE = 3'b100
    } emb_state_type;

    // Access request from the core.
    typedef struct packed {
        logic valid;
        logic write;
        logic [17:0] addr;
        logic [23:0] wdata;
        logic [3:0] attr;
    } emb_req_type;

    // Output pin group, values and enables.
    typedef struct packed {
        logic [17:0] addr;
        logic addrOe;
        logic [23:0] data;
        logic dataOe;
        logic [3:0] attr;
        logic attrOe;
        logic readN;
        logic writeN;
        logic strobeOe;
        logic busBusyN;
        logic busBusyOe;
    } emb_pins_type;

endpackage : emb_pkg

/* File: hw/emb_port.sv */
// Function
// - Stop or wait releases the bus and floats every port output.
// - Owner drives 18 address lines; otherwise and in reset they float.
// - Address lines hold their value when no external access happens.
// - Owner uses 24 data lines bidirectionally; otherwise they float.
// - Data ignored in reset; in standby inputs ignored, outputs float.
// - Owner asserts low read or write strobe; otherwise strobes float.
// - One attribute line at a time unless priority disable bit is set.
//
// The port owns the external bus only while the synchronised grant is
// high and the synchronised standby request is low. Every output enable
// is decoded from the state register and wrQ alone, so the whole port floats
// within one edge of losing ownership.
// Values on the pins are registered and held between accesses, which
// keeps the address lines quiet when nothing external is addressed.
// The data bus is driven only during the write strobe cycle and is an
// input at every other time.
// Requests that arrive while the port does not own the bus are dropped.
module emb_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic busGrant,
    input wire logic standby,
    input wire logic [23:0] modeWord,
    input wire emb_pkg::emb_req_type req,
    input wire logic [23:0] dataIn,
    output emb_pkg::emb_pins_type pins,
    output logic [23:0] readData,
    output logic readValid,
    output logic owner
);

    //////////////////////////////////////////////////////////////////////
    // Pin inputs cross from outside the clock domain.
    // Only the second stage of each pair is read by the logic, so a
    // metastable first stage never reaches a decision.
    logic grantMeta;
    logic grantSync;
    logic stbyMeta;
    logic stbySync;
    logic [23:0] dataMeta;
    logic [23:0] dataSync;
    logic next_grantMeta;
    logic next_stbyMeta;

    // Two-stage synchronisers for grant, standby and the data bus.
    // The data bus is sampled through the same two stages, so read data
    // lags the pins by two cycles; memory must hold it that long.
    always_comb begin
        next_grantMeta = busGrant;
        next_stbyMeta = standby;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            grantMeta <= 1'b0;
            grantSync <= 1'b0;
            stbyMeta <= 1'b0;
            stbySync <= 1'b0;
            dataMeta <= emb_pkg::DATA_RESET;
            dataSync <= emb_pkg::DATA_RESET;
        end else begin
            grantMeta <= next_grantMeta;
            grantSync <= grantMeta;
            stbyMeta <= next_stbyMeta;
            stbySync <= stbyMeta;
            dataMeta <= dataIn;
            dataSync <= dataMeta;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Keeps only the lowest asserted attribute line in priority mode.
    // The loop runs from the top down so that the last hit, the lowest
    // line, wins. With the disable bit set this function is bypassed and
    // all four lines pass, which lets outside logic decode them into
    // sixteen selects.
    // An empty request gives an empty result.
    function automatic logic [3:0] emb_prio(input logic [3:0] a);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 3; i >= 0; i--) begin
            if (a[i]) begin
                r = 4'h0;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction : emb_prio

    //////////////////////////////////////////////////////////////////////
    // Ownership state and registered pin values.
    emb_pkg::emb_state_type state, next_state;
    logic [17:0] addrQ, next_addrQ;
    logic [23:0] dataQ, next_dataQ;
    logic [3:0] attrQ, next_attrQ;
    // The strobe flags live for one cycle each; lastOut remembers the
    // direction of the last transfer, though no logic in the port reads it.
    logic rdQ;
    logic next_rdQ;
    logic wrQ;
    logic next_wrQ;
    logic lastOut;
    logic next_lastOut;
    logic [23:0] rdataQ, next_rdataQ;
    logic rvalidQ, next_rvalidQ;
    logic access;

    // Requests are served only while owning the bus.
    always_comb begin
        access = (state == emb_pkg::EMB_OWNER) && req.valid;
        next_state = state;
        next_addrQ = addrQ;
        next_dataQ = dataQ;
        next_attrQ = attrQ;
        next_rdQ = 1'b0;
        next_wrQ = 1'b0;
        next_lastOut = lastOut;
        next_rdataQ = rdataQ;
        next_rvalidQ = 1'b0;
        // The state leaves reset through idle, never straight to owner,
        // so the grant has passed its synchroniser before any enable
        // rises.
        unique case (state)
            emb_pkg::EMB_RESET: begin
                next_state = emb_pkg::EMB_IDLE;
            end
            emb_pkg::EMB_OWNER: begin
                if (stbySync || !grantSync) begin
                    next_state = emb_pkg::EMB_IDLE;
                end
            end
            emb_pkg::EMB_IDLE: begin
                if (grantSync && !stbySync) begin
                    next_state = emb_pkg::EMB_OWNER;
                end
            end
        endcase
        // An access is taken only when ownership will also hold in the
        // next cycle; a request in the cycle that ownership is lost is
        // refused, so no strobe appears on a floating bus.
        // Address, attribute and write data stay registered afterwards.
        if (access && !stbySync && grantSync) begin
            next_addrQ = req.addr;
            next_rdQ = !req.write;
            next_wrQ = req.write;
            next_lastOut = req.write;
            if (req.write) begin
                next_dataQ = req.wdata;
            end
            if (modeWord[emb_pkg::ATTR_PRIORITY_DISABLE_BIT]) begin
                next_attrQ = req.attr;
            end else begin
                next_attrQ = emb_prio(req.attr);
            end
        end
        // Read data is taken at the edge that ends the read strobe cycle; never in reset.
        if (rdQ && state == emb_pkg::EMB_OWNER) begin
            next_rdataQ = dataSync;
            next_rvalidQ = 1'b1;
        end
    end

    // Registers only; reset puts the port in its floating state.
    // The reset is synchronous, so it must be held for one edge at least
    // before the enables are known to be low.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= emb_pkg::EMB_RESET;
            addrQ <= emb_pkg::ADDR_RESET;
            dataQ <= emb_pkg::DATA_RESET;
            attrQ <= emb_pkg::ATTR_RESET;
            rdQ <= 1'b0;
            wrQ <= 1'b0;
            lastOut <= 1'b0;
            rdataQ <= emb_pkg::DATA_RESET;
            rvalidQ <= 1'b0;
        end else begin
            state <= next_state;
            addrQ <= next_addrQ;
            dataQ <= next_dataQ;
            attrQ <= next_attrQ;
            rdQ <= next_rdQ;
            wrQ <= next_wrQ;
            lastOut <= next_lastOut;
            rdataQ <= next_rdataQ;
            rvalidQ <= next_rvalidQ;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Pin drive; all enables fall together when ownership is lost.
    // The enables are combinational from the state register and wrQ only, so
    // they carry no glitch from the request inputs.
    // The strobes are gated with ownership as well as their own enable,
    // which keeps them inactive in the cycle that the bus is released.
    // Bus busy is driven low for as long as the port owns the bus and
    // floats with everything else otherwise.
    always_comb begin
        owner = (state == emb_pkg::EMB_OWNER);
        pins.addr = addrQ;
        pins.addrOe = owner;
        pins.data = dataQ;
        pins.dataOe = owner && wrQ;
        pins.attr = attrQ;
        pins.attrOe = owner;
        pins.readN = !(owner && rdQ);
        pins.writeN = !(owner && wrQ);
        pins.strobeOe = owner;
        pins.busBusyN = !owner;
        pins.busBusyOe = owner;
        readData = rdataQ;
        readValid = rvalidQ;
    end

endmodule : emb_port

/* File: verif/emb_mem_model.sv */
module emb_mem_model (
    input wire logic clk,
    input wire emb_pkg::emb_pins_type pins,
    output logic [23:0] dataIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] mem [16];
    // Writes land on the strobe edge; the array is small, so addresses alias.
    always @(posedge clk) begin
        if (pins.strobeOe && !pins.writeN && pins.dataOe) begin
            mem[pins.addr[3:0]] <= pins.data;
        end
    end
    // The held address keeps data steady; a released bus shows inverted data.
    always_comb begin
        dataIn = mem[pins.addr[3:0]] ^ {24{!pins.addrOe}};
    end
endmodule : emb_mem_model

/* File: verif/emb_port_asserts.sv */
module emb_port_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic standby,
    input wire logic [23:0] modeWord,
    input wire emb_pkg::emb_req_type req,
    input wire emb_pkg::emb_pins_type pins,
    input wire logic readValid,
    input wire logic owner
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Enables follow ownership, so standby or a lost grant floats the port.
    stby_float_a: assert property (
        standby [*4] |-> !owner && !pins.busBusyOe) else $error("no float");
    addr_float_a: assert property (
        !owner |-> !pins.addrOe && !pins.attrOe) else $error("addr driven");
    addr_hold_a: assert property (
        !$past(req.valid && owner) |-> $stable(pins.addr))
        else $error("addr moved");
    data_float_a: assert property (
        pins.dataOe |-> owner && !pins.writeN) else $error("data driven");
    read_pulse_a: assert property (
        readValid |-> $past(!pins.readN)) else $error("stray read");
    strobe_kind_a: assert property (
        req.valid && owner |=> $past(req.write) ? !pins.writeN : !pins.readN)
        else $error("no strobe");
    attr_one_a: assert property (
        $past(req.valid && owner &&
        !modeWord[emb_pkg::ATTR_PRIORITY_DISABLE_BIT]) |->
        $onehot0(pins.attr))
        else $error("attr overlap");
    // Covers show the read, write and standby paths were reached.
    cov_read: cover property (readValid);
    cov_write: cover property (!pins.writeN);
    cov_stby: cover property (standby [*4]);
endmodule : emb_port_asserts
////////////////////////////////////////////////////////////////////////
bind emb_port emb_port_asserts u_asserts (.clk(clk), .rst_n(rst_n),
    .standby(standby), .modeWord(modeWord), .req(req), .pins(pins),
    .readValid(readValid), .owner(owner));

/* File: verif/emb_port_test.sv */
module emb_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, busGrant, standby, readValid, owner;
    logic [23:0] modeWord, dataIn, readData, oes;
    emb_pkg::emb_req_type req;
    emb_pkg::emb_pins_type pins;
    int err_total, checks_done, cyc;
    emb_port dut (.clk(clk), .rst_n(rst_n), .busGrant(busGrant),
        .standby(standby), .modeWord(modeWord), .req(req), .dataIn(dataIn),
        .pins(pins), .readData(readData), .readValid(readValid),
        .owner(owner));
    emb_mem_model mem (.clk(clk), .pins(pins), .dataIn(dataIn));
    // Every enable gathered so one compare proves the whole port floats.
    assign oes = {18'h0, owner, pins.addrOe, pins.dataOe, pins.attrOe,
        pins.strobeOe, pins.busBusyOe};
    ////////////////////////////////////////////////////////////////////
    task automatic chk(string n, logic [23:0] e, logic [23:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic acc(logic w, logic [17:0] a, logic [23:0] d,
        logic [3:0] t);
        req = '{1'b1, w, a, d, t};
        @(negedge clk);
        req.valid = 1'b0;
    endtask : acc
    task automatic own();
        for (int i = 0; i < 20 && owner !== 1'b1; i++) @(negedge clk);
        chk("own", 24'h1, {23'h0, owner});
    endtask : own
    // Write then read back; the address must hold after the read.
    task automatic t_rw();
        acc(1'b1, 18'h00005, 24'hA5C3E1, 4'h2);
        chk("wr", 24'h1, {22'h0, pins.writeN, pins.dataOe});
        chk("wd", 24'hA5C3E1, pins.data);
        chk("busy", 24'h0, {23'h0, pins.busBusyN});
        repeat (3) @(negedge clk);
        acc(1'b0, 18'h00005, 24'h000000, 4'h2);
        chk("rd", 24'h0, {22'h0, pins.readN, pins.dataOe});
        @(negedge clk);
        chk("rv", 24'h1, {23'h0, readValid});
        chk("rdat", 24'hA5C3E1, readData);
        repeat (4) @(negedge clk);
        chk("ahold", 24'h5, {6'h0, pins.addr});
    endtask : t_rw
    // All attribute lines requested, with and without priority.
    task automatic t_attr();
        acc(1'b1, 18'h3FFFF, 24'h000000, 4'hF);
        chk("pri", 24'h1, {20'h0, pins.attr});
        modeWord = 24'h004000;
        @(negedge clk);
        acc(1'b1, 18'h3FFFF, 24'h000000, 4'hF);
        chk("nopri", 24'hF, {20'h0, pins.attr});
        modeWord = 24'h000000;
    endtask : t_attr
    // Standby, then loss of grant, must each float the port.
    task automatic t_stby();
        standby = 1'b1;
        repeat (5) @(negedge clk);
        chk("stby", 24'h0, oes);
        standby = 1'b0;
        own();
        busGrant = 1'b0;
        repeat (5) @(negedge clk);
        chk("grant", 24'h0, oes);
    endtask : t_stby
    task automatic results();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // The run needs about forty cycles; the ceiling leaves wide margin.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            err_total++;
            results();
        end
    end
    initial begin
        {rst_n, busGrant, standby} = 3'b010;
        modeWord = 24'h000000;
        req = '0;
        repeat (8) @(negedge clk);
        chk("rst", 24'h0, oes);
        rst_n = 1'b1;
        own();
        t_rw();
        t_attr();
        t_stby();
        results();
    end
endmodule : emb_port_test
